// [dv/dpio_host_model.sv]
// Host processor model on the slave port strobes and port D
module dpio_host_model (
    input wire logic aclk,
    input wire logic [7:0] pin_d_out,
    output logic [7:0] host_d,
    output logic host_d_en,
    output logic [2:0] strobe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        host_d = 8'h00;
        host_d_en = 1'h0;
        strobe_n = 3'h7;
    end
    // Six clocks each way, margin over the three the port needs
    task automatic host_write(input logic [7:0] val);
        host_d <= val;
        host_d_en <= 1'h1;
        strobe_n <= 3'h1;
        repeat (6) @(posedge aclk);
        strobe_n <= 3'h3;
        repeat (2) @(posedge aclk);
        strobe_n <= 3'h7;
        host_d_en <= 1'h0;
        repeat (6) @(posedge aclk);
    endtask : host_write
    task automatic host_read(output logic [7:0] val);
        strobe_n <= 3'h2;
        repeat (6) @(posedge aclk);
        val = pin_d_out;
        strobe_n <= 3'h7;
        repeat (6) @(posedge aclk);
    endtask : host_read
endmodule : dpio_host_model

// [dv/dpio_props.sv]
// Concurrent checks on the dual port block pins and register bus
`include "dpio_params.svh"

module dpio_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic soft_reset_n,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic [31:0] rdata,
    input wire logic [7:0] pin_d_out,
    input wire logic [7:0] pin_d_oe_n,
    input wire logic [7:0] pin_e_in,
    input wire logic [7:0] pin_e_out,
    input wire logic [7:0] pin_e_oe_n,
    input wire logic [15:0] ebus_ad_out,
    input wire logic ebus_drive,
    input wire logic ebus_active,
    input wire logic schmitt_sel_d,
    input wire logic schmitt_sel_e
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence bus_driving;
        ebus_active && ebus_drive ##1 ebus_active && ebus_drive;
    endsequence
    // Five samples cover two sync flops plus the output register
    sequence host_read_low;
        (!ebus_active && !schmitt_sel_d && pin_e_in[2:0] == 3'h2) [*5];
    endsequence

    chk_soft_dir_reset: assert property (!soft_reset_n |-> ##2 (ebus_active || pin_d_oe_n == 8'hFF))
        else $error("direction not restored by soft reset");
    chk_bus_ttl_select: assert property ($rose(ebus_active) |-> ##[0:2] !schmitt_sel_d && !schmitt_sel_e)
        else $error("input buffers not switched for bus");
    chk_bus_pin_drive: assert property (bus_driving |-> pin_d_oe_n == 8'h00 && {pin_e_out, pin_d_out} == $past(ebus_ad_out))
        else $error("bus value not on pins");
    chk_host_read_drive: assert property (host_read_low |-> pin_d_oe_n == 8'h00)
        else $error("port D not driven on host read");
    chk_slave_ctl_inputs: assert property ((!ebus_active && !schmitt_sel_e) [*2] |-> pin_e_oe_n[2:0] == 3'h7)
        else $error("slave control pins driven");
    chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    chk_read_answer: assert property (arvalid && arready |=> rvalid && rdata[31:8] == 24'h00_0000)
        else $error("read answer late or upper bits set");
    chk_busy_refuse: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while response pending");
endmodule : dpio_props

bind dpio_top dpio_props u_props (
    .aclk(aclk), .aresetn(aresetn), .soft_reset_n(soft_reset_n), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
    .arready(arready), .rvalid(rvalid), .rdata(rdata), .pin_d_out(pin_d_out),
    .pin_d_oe_n(pin_d_oe_n), .pin_e_in(pin_e_in), .pin_e_out(pin_e_out),
    .pin_e_oe_n(pin_e_oe_n), .ebus_ad_out(ebus_ad_out), .ebus_drive(ebus_drive),
    .ebus_active(ebus_active), .schmitt_sel_d(schmitt_sel_d), .schmitt_sel_e(schmitt_sel_e)
);

// [dv/test_dual_port_io_bus_mux.sv]
// Self-checking bench for the dual port block
`include "dpio_params.svh"

module test_dual_port_io_bus_mux;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, awready, wready, bvalid, arready, rvalid, ebus_active, c2_in, sch_d, sch_e, host_d_en;
    logic aresetn = 1'h0, soft_reset_n = 1'h1, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0, ebus_drive = 1'h0, c2_out = 1'h0, c2_drive = 1'h0;
    logic [1:0] strap = 2'h0, bresp, rresp;
    logic alt_sel = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, tb_d = 8'h00;
    logic [7:0] pin_d_in, pin_d_out, pin_d_oe_n, pin_e_in, pin_e_out, pin_e_oe_n, host_d;
    logic [2:0] strobe_n;
    logic [15:0] ebus_ad_out = 16'h0000, ebus_ad_in;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    int err_total, checks_done, cycles;

    assign pin_d_in = (pin_d_out & ~pin_d_oe_n) | ((host_d_en ? host_d : tb_d) & pin_d_oe_n);
    assign pin_e_in = (pin_e_out & ~pin_e_oe_n) | ({5'h1A, strobe_n} & pin_e_oe_n);

    dpio_top dut_u (
        .aclk(aclk), .aresetn(aresetn), .ce(1'h1), .soft_reset_n(soft_reset_n),
        .mem_mode_strap(strap), .capture2_pin_alt_select(alt_sel), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .pin_d_in(pin_d_in), .pin_d_out(pin_d_out), .pin_d_oe_n(pin_d_oe_n),
        .pin_e_in(pin_e_in), .pin_e_out(pin_e_out), .pin_e_oe_n(pin_e_oe_n),
        .ebus_ad_out(ebus_ad_out), .ebus_drive(ebus_drive), .ebus_ad_in(ebus_ad_in),
        .ebus_active(ebus_active), .capture2_out(c2_out), .capture2_drive(c2_drive),
        .capture2_in(c2_in), .schmitt_sel_d(sch_d), .schmitt_sel_e(sch_e)
    );
    dpio_host_model host_u (
        .aclk(aclk), .pin_d_out(pin_d_out), .host_d(host_d), .host_d_en(host_d_en),
        .strobe_n(strobe_n)
    );

    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        bready <= 1'h0;
        check({6'h0, bresp}, {6'h0, `DPIO_RESP_OKAY});
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : reg_rd
    task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        reg_rd(a, d, r);
        check({6'h0, r}, {6'h0, `DPIO_RESP_OKAY});
        check(d[7:0], exp);
    endtask : reg_chk
    task automatic do_reset(input logic [1:0] m);
        aresetn <= 1'h0;
        strap <= m;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
    endtask : do_reset

    task automatic t_reset_and_regs;
        logic [31:0] d;
        logic [1:0] r;
        reg_chk(`DPIO_OFS_DIR_D, `DPIO_DIR_RST);
        reg_chk(`DPIO_OFS_DIR_E, `DPIO_DIR_RST);
        reg_chk(`DPIO_OFS_SPC, 8'h00);
        check(pin_d_oe_n, 8'hFF);
        check({7'h0, sch_d}, 8'h01);
        reg_wr(`DPIO_OFS_MIC, 8'hFF);
        reg_chk(`DPIO_OFS_MIC, `DPIO_MIC_MASK);
        reg_wr(`DPIO_OFS_MIC, 8'h00);
        reg_wr(`DPIO_OFS_SPC, 8'h0F);
        reg_chk(`DPIO_OFS_SPC, 8'h00);
        reg_rd(8'h20, d, r);
        check({r, d[5:0]}, {`DPIO_RESP_SLVERR, 6'h00});
    endtask : t_reset_and_regs
    task automatic t_ports;
        tb_d <= 8'h5A;
        reg_wr(`DPIO_OFS_LAT_D, 8'hA5);
        reg_wr(`DPIO_OFS_DIR_D, 8'h0F);
        reg_wr(`DPIO_OFS_LAT_E, 8'h3C);
        reg_wr(`DPIO_OFS_DIR_E, 8'hF0);
        repeat (3) @(posedge aclk);
        check(pin_d_oe_n, 8'h0F);
        check(pin_d_out | 8'h0F, 8'hAF);
        check(pin_e_oe_n, 8'hF0);
        check(pin_e_out | 8'hF0, 8'hFC);
        reg_chk(`DPIO_OFS_LAT_D, 8'hA5);
        reg_chk(`DPIO_OFS_PIN_D, 8'hAA);
        reg_chk(`DPIO_OFS_LAT_E, 8'h3C);
        reg_chk(`DPIO_OFS_PIN_E, 8'hDC);
        reg_wr(`DPIO_OFS_DIR_E, 8'h70);
        c2_drive <= 1'h1;
        c2_out <= 1'h1;
        repeat (5) @(posedge aclk);
        check({pin_e_oe_n[7], pin_e_out[7], c2_in, 5'h0}, 8'h60);
        c2_drive <= 1'h0;
    endtask : t_ports
    task automatic t_slave_port;
        logic [7:0] v;
        reg_wr(`DPIO_OFS_DIR_D, 8'hFF);
        reg_wr(`DPIO_OFS_DIR_E, 8'hFF);
        reg_wr(`DPIO_OFS_SPC, 8'h10);
        repeat (3) @(posedge aclk);
        check({7'h0, sch_d}, 8'h00);
        host_u.host_write(8'h77);
        reg_chk(`DPIO_OFS_SPC, 8'h90);
        reg_chk(`DPIO_OFS_PIN_D, 8'h77);
        reg_chk(`DPIO_OFS_SPC, 8'h10);
        reg_wr(`DPIO_OFS_PIN_D, 8'h3C);
        reg_chk(`DPIO_OFS_SPC, 8'h50);
        host_u.host_read(v);
        check(v, 8'h3C);
        reg_chk(`DPIO_OFS_SPC, 8'h10);
        reg_wr(`DPIO_OFS_SPC, 8'h00);
    endtask : t_slave_port
    task automatic t_soft_reset;
        reg_wr(`DPIO_OFS_DIR_D, 8'h00);
        soft_reset_n <= 1'h0;
        repeat (2) @(posedge aclk);
        soft_reset_n <= 1'h1;
        @(posedge aclk);
        reg_chk(`DPIO_OFS_LAT_D, 8'h3C);
        reg_chk(`DPIO_OFS_DIR_D, 8'hFF);
        reg_chk(`DPIO_OFS_LAT_E, 8'h3C);
    endtask : t_soft_reset
    task automatic t_bus_modes;
        for (logic [1:0] m = 2'h1; m < 2'h3; m++) begin
            ebus_ad_out <= 16'hBEEF;
            ebus_drive <= 1'h1;
            do_reset(m);
            @(posedge aclk);
            check({7'h0, ebus_active}, 8'h01);
            repeat (3) @(posedge aclk);
            check(ebus_ad_in[7:0], 8'hEF);
            check(ebus_ad_in[15:8], 8'hBE);
            check(pin_d_out, 8'hEF);
            check(pin_e_out, 8'hBE);
            check(pin_d_oe_n | pin_e_oe_n, 8'h00);
            check({6'h0, sch_d, sch_e}, 8'h00);
            reg_wr(`DPIO_OFS_MIC, 8'h80);
            repeat (3) @(posedge aclk);
            check({6'h0, ebus_active, sch_d}, 8'h01);
        end
        ebus_drive <= 1'h0;
    endtask : t_bus_modes
    task automatic t_alt_off;
        alt_sel <= 1'h1;
        do_reset(2'h0);
        reg_wr(`DPIO_OFS_DIR_E, 8'h70);
        c2_drive <= 1'h1;
        repeat (5) @(posedge aclk);
        check({pin_e_oe_n[7], pin_e_out[7], c2_in, 5'h0}, 8'h00);
        c2_drive <= 1'h0;
    endtask : t_alt_off

    initial begin
        do_reset(2'h0);
        t_reset_and_regs();
        t_ports();
        t_slave_port();
        t_soft_reset();
        t_bus_modes();
        t_alt_off();
        final_report();
    end
endmodule : test_dual_port_io_bus_mux

// [verilog/dpio_params.svh]
// Register offsets, field positions and reset values of the dual port block
`ifndef DPIO_PARAMS_SVH
`define DPIO_PARAMS_SVH
`define DPIO_OFS_PIN_D 8'h00
`define DPIO_OFS_LAT_D 8'h04
`define DPIO_OFS_DIR_D 8'h08
`define DPIO_OFS_PIN_E 8'h0C
`define DPIO_OFS_LAT_E 8'h10
`define DPIO_OFS_DIR_E 8'h14
`define DPIO_OFS_SPC 8'h18
`define DPIO_OFS_MIC 8'h1C
`define DPIO_DIR_RST 8'hFF
`define DPIO_LAT_RST 8'h00
`define DPIO_SPC_RST 8'h00
`define DPIO_MIC_RST 8'h00
`define DPIO_SPC_MASK 8'hF0
`define DPIO_MIC_MASK 8'hB3
`define DPIO_SPC_IBF 7
`define DPIO_SPC_OBF 6
`define DPIO_SPC_INPUT_BUFFER_OVERFLOW 5
`define DPIO_SPC_MODE 4
`define DPIO_MIC_EXTERNAL_BUS_DISABLE 7
`define DPIO_E_RD 0
`define DPIO_E_WR 1
`define DPIO_E_CS 2
`define DPIO_E_ALT 7
`define DPIO_PSP_CTL_BITS 8'h07
`define DPIO_RESP_OKAY 2'h0
`define DPIO_RESP_SLVERR 2'h2
`endif

// [verilog/dpio_pkg.sv]
// Types shared by the dual port block
package dpio_pkg;
    typedef enum logic [2:0] {
        DPIO_MODE_MCU = 3'h1,
        DPIO_MODE_MPU = 3'h2,
        DPIO_MODE_EXT = 3'h4
    } dpio_mem_mode_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } dpio_pin_drv_t;

    typedef struct packed {
        logic input_buffer_full;
        logic output_buffer_full;
        logic input_buffer_overflow;
        logic mode;
    } dpio_spc_t;
endpackage : dpio_pkg

// [verilog/dpio_top.sv]
// Ports D and E with pin sharing between I/O, external bus and slave port
// Summary of operation
// - Port D direction bit one makes the pin an input, driver off.
// - Port D direction bit zero drives the output latch bit onto the pin.
// - Port D latch is mapped; reading it returns the latch, not pins.
// - Power-on reset sets every port D direction bit to one.
// - Port D is general I/O in microcontroller mode or while external bus disable is set.
// - With external bus active, port D carries the low address/data byte.
// - Slave port mode bit turns port D into a host-accessed 8-bit port.
// - Schmitt buffers in I/O mode, TTL buffers in bus or slave port mode.
// - Port E direction one is input, zero drives the latch value.
// - Reading the port E latch returns the latch, not the pins.
// - Port E is general I/O in microcontroller mode or while external bus disable is set.
// - Microprocessor or extended mode: port E is the high address/data byte.
// - Microcontroller mode with slave port mode: E2..E0 are slave controls.
// - Microcontroller mode, alternate select clear: capture unit 2 uses E7.
// - Extended mode on larger package: port E is bus right after reset.
// - Slave port control works only in microcontroller mode on bus parts.
// - Unimplemented slave port and memory control bits read as zero.
//
// The address map and the AXI4-Lite slave port were decided locally.
`include "dpio_params.svh"

module dpio_top #(
    parameter bit HAS_EMI = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic soft_reset_n,
    input wire logic [1:0] mem_mode_strap,
    input wire logic capture2_pin_alt_select,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [7:0] pin_d_in,
    output logic [7:0] pin_d_out,
    output logic [7:0] pin_d_oe_n,
    input wire logic [7:0] pin_e_in,
    output logic [7:0] pin_e_out,
    output logic [7:0] pin_e_oe_n,
    input wire logic [15:0] ebus_ad_out,
    input wire logic ebus_drive,
    output logic [15:0] ebus_ad_in,
    output logic ebus_active,
    input wire logic capture2_out,
    input wire logic capture2_drive,
    output logic capture2_in,
    output logic schmitt_sel_d,
    output logic schmitt_sel_e
);

    logic [7:0] output_latch_d_r;
    logic [7:0] pin_direction_d_r;
    logic [7:0] output_latch_e_r;
    logic [7:0] pin_direction_e_r;
    logic [7:0] psp_in_buf_r;
    dpio_pkg::dpio_spc_t spc_r;
    logic external_bus_disable_r;
    logic [1:0] bus_wait_r;
    logic [1:0] write_style_r;
    dpio_pkg::dpio_mem_mode_t mode_r;
    logic alt_sel_r;
    logic [7:0] d_meta_r;
    logic [7:0] d_sync_r;
    logic [7:0] e_meta_r;
    logic [7:0] e_sync_r;
    logic [7:0] e_prev_r;
    logic bus_on;
    logic psp_on;
    logic host_sel;
    logic host_rd;
    logic host_wr_done;
    logic host_rd_done;
    logic alt_on;
    dpio_pkg::dpio_pin_drv_t drv_d;
    dpio_pkg::dpio_pin_drv_t drv_e;
    logic [7:0] aw_addr_r;
    logic aw_held_r;
    logic [7:0] w_data_r;
    logic w_strb0_r;
    logic w_held_r;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] rd_val;
    logic rd_hit;
    logic wr_hit;
    logic sw_rd_pin_d;
    logic sw_wr_lat_d;

    function automatic dpio_pkg::dpio_mem_mode_t decode_mode(input logic [1:0] s);
        case (s)
            2'h1: decode_mode = dpio_pkg::DPIO_MODE_MPU;
            2'h2: decode_mode = dpio_pkg::DPIO_MODE_EXT;
            default: decode_mode = dpio_pkg::DPIO_MODE_MCU;
        endcase
    endfunction : decode_mode

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            `DPIO_OFS_PIN_D, `DPIO_OFS_LAT_D, `DPIO_OFS_DIR_D,
            `DPIO_OFS_PIN_E, `DPIO_OFS_LAT_E, `DPIO_OFS_DIR_E,
            `DPIO_OFS_SPC, `DPIO_OFS_MIC: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    // Straps caught while reset is held, so mode is stable from release on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= decode_mode(mem_mode_strap);
            alt_sel_r <= capture2_pin_alt_select;
        end
    end

    // Pins cross in through two flops before any logic looks at them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            d_meta_r <= 8'h00;
            d_sync_r <= 8'h00;
            e_meta_r <= 8'hFF;
            e_sync_r <= 8'hFF;
            e_prev_r <= 8'hFF;
        end else if (ce) begin
            d_meta_r <= pin_d_in;
            d_sync_r <= d_meta_r;
            e_meta_r <= pin_e_in;
            e_sync_r <= e_meta_r;
            e_prev_r <= e_sync_r;
        end
    end

    always_comb begin
        bus_on = HAS_EMI && !external_bus_disable_r
            && (mode_r != dpio_pkg::DPIO_MODE_MCU);
        psp_on = spc_r.mode && !bus_on
            && (!HAS_EMI || mode_r == dpio_pkg::DPIO_MODE_MCU);
        host_sel = !e_sync_r[`DPIO_E_CS];
        host_rd = psp_on && host_sel && !e_sync_r[`DPIO_E_RD];
        host_wr_done = psp_on && !e_prev_r[`DPIO_E_WR] && e_sync_r[`DPIO_E_WR]
            && !e_prev_r[`DPIO_E_CS];
        host_rd_done = psp_on && !e_prev_r[`DPIO_E_RD] && e_sync_r[`DPIO_E_RD]
            && !e_prev_r[`DPIO_E_CS];
        alt_on = (mode_r == dpio_pkg::DPIO_MODE_MCU) && !alt_sel_r;
    end

    always_comb begin
        if (bus_on) begin
            drv_d.out = ebus_ad_out[7:0];
            drv_d.oe_n = {8{!ebus_drive}};
        end else if (psp_on) begin
            drv_d.out = output_latch_d_r;
            drv_d.oe_n = {8{!host_rd}};
        end else begin
            drv_d.out = output_latch_d_r;
            drv_d.oe_n = pin_direction_d_r;
        end
        if (bus_on) begin
            drv_e.out = ebus_ad_out[15:8];
            drv_e.oe_n = {8{!ebus_drive}};
        end else begin
            drv_e.out = output_latch_e_r;
            drv_e.oe_n = pin_direction_e_r;
            if (alt_on && capture2_drive) begin
                drv_e.out[`DPIO_E_ALT] = capture2_out;
            end
            if (psp_on) begin
                // Strobes stay inputs even if software left them as outputs
                drv_e.oe_n = pin_direction_e_r | `DPIO_PSP_CTL_BITS;
            end
        end
    end

    // Pin outputs registered, one cycle behind the select logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_d_out <= 8'h00;
            pin_d_oe_n <= 8'hFF;
            pin_e_out <= 8'h00;
            pin_e_oe_n <= 8'hFF;
            ebus_ad_in <= 16'h0000;
            ebus_active <= 1'b0;
            capture2_in <= 1'b0;
            schmitt_sel_d <= 1'b1;
            schmitt_sel_e <= 1'b1;
        end else if (ce) begin
            pin_d_out <= drv_d.out;
            pin_d_oe_n <= drv_d.oe_n;
            pin_e_out <= drv_e.out;
            pin_e_oe_n <= drv_e.oe_n;
            ebus_ad_in <= {e_sync_r, d_sync_r};
            ebus_active <= bus_on;
            capture2_in <= alt_on & e_sync_r[`DPIO_E_ALT];
            schmitt_sel_d <= !(bus_on || psp_on);
            schmitt_sel_e <= !(bus_on || psp_on);
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    assign awready = ce && !aw_held_r && !bvalid;
    assign wready = ce && !w_held_r && !bvalid;
    assign wr_fire = ce && aw_held_r && w_held_r && !bvalid;
    assign wr_hit = wr_fire && is_mapped(aw_addr_r) && w_strb0_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r <= 1'b0;
            w_data_r <= 8'h00;
            w_strb0_r <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `DPIO_RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {awaddr[7:2], 2'h0};
            end
            if (wvalid && wready) begin
                w_held_r <= 1'b1;
                w_data_r <= wdata[7:0];
                w_strb0_r <= wstrb[0];
            end
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid <= 1'b1;
                bresp <= is_mapped(aw_addr_r) ? `DPIO_RESP_OKAY : `DPIO_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read path
    assign arready = ce && !rvalid;
    assign rd_fire = arvalid && arready;
    assign rd_hit = is_mapped({araddr[7:2], 2'h0});

    always_comb begin
        case ({araddr[7:2], 2'h0})
            `DPIO_OFS_PIN_D: rd_val = psp_on ? psp_in_buf_r : d_sync_r;
            `DPIO_OFS_LAT_D: rd_val = output_latch_d_r;
            `DPIO_OFS_DIR_D: rd_val = pin_direction_d_r;
            `DPIO_OFS_PIN_E: rd_val = e_sync_r;
            `DPIO_OFS_LAT_E: rd_val = output_latch_e_r;
            `DPIO_OFS_DIR_E: rd_val = pin_direction_e_r;
            `DPIO_OFS_SPC: rd_val = {spc_r, 4'h0};
            `DPIO_OFS_MIC: rd_val = {external_bus_disable_r, 1'b0, bus_wait_r,
                2'h0, write_style_r};
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= `DPIO_RESP_OKAY;
        end else if (ce) begin
            if (rd_fire) begin
                rvalid <= 1'b1;
                rdata <= {24'h000000, rd_val};
                rresp <= rd_hit ? `DPIO_RESP_OKAY : `DPIO_RESP_SLVERR;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    assign sw_rd_pin_d = rd_fire && ({araddr[7:2], 2'h0} == `DPIO_OFS_PIN_D);
    assign sw_wr_lat_d = wr_hit && (aw_addr_r == `DPIO_OFS_PIN_D
        || aw_addr_r == `DPIO_OFS_LAT_D);

    // Latches survive soft resets; only a power-on reset clears them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_latch_d_r <= `DPIO_LAT_RST;
            output_latch_e_r <= `DPIO_LAT_RST;
        end else if (ce && wr_hit) begin
            if (sw_wr_lat_d) begin
                output_latch_d_r <= w_data_r;
            end
            if (aw_addr_r == `DPIO_OFS_PIN_E || aw_addr_r == `DPIO_OFS_LAT_E) begin
                output_latch_e_r <= w_data_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !soft_reset_n) begin
            pin_direction_d_r <= `DPIO_DIR_RST;
            pin_direction_e_r <= `DPIO_DIR_RST;
        end else if (ce && wr_hit) begin
            if (aw_addr_r == `DPIO_OFS_DIR_D) begin
                pin_direction_d_r <= w_data_r;
            end
            if (aw_addr_r == `DPIO_OFS_DIR_E) begin
                pin_direction_e_r <= w_data_r;
            end
        end
    end

    // Bus disable clear at reset: extended mode owns port E at once
    always_ff @(posedge aclk) begin
        if (!aresetn || !soft_reset_n) begin
            external_bus_disable_r <= 1'(`DPIO_MIC_RST >> `DPIO_MIC_EXTERNAL_BUS_DISABLE);
            bus_wait_r <= 2'h0;
            write_style_r <= 2'h0;
        end else if (ce && wr_hit && aw_addr_r == `DPIO_OFS_MIC && HAS_EMI) begin
            external_bus_disable_r <= w_data_r[`DPIO_MIC_EXTERNAL_BUS_DISABLE];
            bus_wait_r <= w_data_r[5:4];
            write_style_r <= w_data_r[1:0];
        end
    end

    // Slave port buffer and flags; a hardware set beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn || !soft_reset_n) begin
            spc_r <= dpio_pkg::dpio_spc_t'(4'(`DPIO_SPC_RST >> `DPIO_SPC_MODE));
            psp_in_buf_r <= 8'h00;
        end else if (ce) begin
            if (wr_hit && aw_addr_r == `DPIO_OFS_SPC) begin
                // Only mode and overflow are software writable
                spc_r.mode <= w_data_r[`DPIO_SPC_MODE];
                if (!w_data_r[`DPIO_SPC_INPUT_BUFFER_OVERFLOW]) begin
                    spc_r.input_buffer_overflow <= 1'b0;
                end
            end
            if (sw_rd_pin_d && psp_on) begin
                spc_r.input_buffer_full <= 1'b0;
            end
            if (host_rd_done) begin
                spc_r.output_buffer_full <= 1'b0;
            end
            if (sw_wr_lat_d && psp_on) begin
                spc_r.output_buffer_full <= 1'b1;
            end
            if (host_wr_done) begin
                psp_in_buf_r <= d_sync_r;
                spc_r.input_buffer_full <= 1'b1;
                if (spc_r.input_buffer_full && !(sw_rd_pin_d && psp_on)) begin
                    spc_r.input_buffer_overflow <= 1'b1;
                end
            end
        end
    end

endmodule : dpio_top
